// *** hw/lcd_cmd_decode.v ***
// command bus decoder with clock-stop and power-down exit readiness
`timescale 1ns/10ps
`include "lcd_consts.vh"
module lcd_cmd_decode #(
    parameter TXP_NCK = `LCD_TXP_NCK
) (
    // clock and reset
    input  wire       clk_sys_in,
    input  wire       rst_b_in,
    // command bus, one sample per bus clock enable
    input  wire       ck_en_in,
    input  wire       cke_in,
    input  wire       cs_in,
    input  wire [5:0] ca_in,
    // configuration
    input  wire       bl_otf_en_in,
    // decoded command
    output reg        cmd_valid_out,
    output reg  [3:0] cmd_code_out,
    output reg  [5:0] cmd_op1_out,
    output reg  [5:0] cmd_op2_out,
    output reg  [2:0] bank_out,
    output reg        all_bank_out,
    output reg        auto_pre_out,
    output reg        burst32_out,
    output reg        col9_out,
    output reg  [9:0] col_out,
    output reg [18:0] row_out,
    // auto-precharge request for the addressed bank
    output reg        auto_pre_req_out,
    // status
    output reg        seq_err_out,
    output wire       ready_out,
    output wire       stop_ok_out
);
    // ------------------------------------------------------------
    // command capture state
    // ------------------------------------------------------------
    localparam S_IDLE   = 2'b01;
    localparam S_SECOND = 2'b10;
    reg  [1:0] state;
    reg  [5:0] first_ca;
    reg  [3:0] pend;        // first half awaiting second half
    reg  [3:0] need_next;   // command that must follow next
    reg  [2:0] pend_bank;
    reg        pend_ap;
    reg  [3:0] code1;
    reg  [3:0] next_need;
    reg        cke_q;
    wire       gap_load;
    wire       gap_zero;
    wire       rdy_zero;
    wire [8:0] rdy_sum;     // exit interval with its carry kept apart
    // classify the first edge; ca0 high with ca1 low is activate-1
    always @* begin
        code1 = `LCD_C_RFU;
        if (ca_in[0] && !ca_in[1])
            code1 = `LCD_C_ACT1;
        else if (ca_in[0] && ca_in[1])
            code1 = `LCD_C_ACT2;
        else begin
            case (ca_in[4:0])   // ca0 is bit 0, as in the opcode constants
                `LCD_OP_MPC:  code1 = `LCD_C_MPC;
                `LCD_OP_PRE:  code1 = `LCD_C_PRE;
                `LCD_OP_REF:  code1 = `LCD_C_REF;
                `LCD_OP_SRE:  code1 = `LCD_C_SRE;
                `LCD_OP_SRX:  code1 = `LCD_C_SRX;
                `LCD_OP_MRW1: code1 = `LCD_C_MRW1;
                `LCD_OP_MRW2: code1 = `LCD_C_MRW2;
                `LCD_OP_MRR1: code1 = `LCD_C_MRR1;
                `LCD_OP_WR1:  code1 = `LCD_C_WR1;
                `LCD_OP_MWR1: code1 = `LCD_C_MWR1;
                `LCD_OP_RD1:  code1 = `LCD_C_RD1;
                `LCD_OP_CAS2: code1 = `LCD_C_CAS2;
                default:      code1 = `LCD_C_RFU;
            endcase
        end
    end
    // what has to come next after the pending first half
    always @* begin
        case (pend)
            `LCD_C_WR1, `LCD_C_MWR1, `LCD_C_RD1,
            `LCD_C_MRR1:  next_need = `LCD_C_CAS2;
            `LCD_C_MPC:   next_need = first_ca[5] ? `LCD_C_NONE
                                                  : `LCD_C_CAS2;
            `LCD_C_MRW1:  next_need = `LCD_C_MRW2;
            `LCD_C_ACT1:  next_need = `LCD_C_ACT2;
            default:      next_need = `LCD_C_NONE;
        endcase
    end
    // ------------------------------------------------------------
    // two-edge sequencer and field extraction
    // ------------------------------------------------------------
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state            <= S_IDLE;
            first_ca         <= 6'h00;
            pend             <= `LCD_C_NONE;
            need_next        <= `LCD_C_NONE;
            pend_bank        <= 3'h0;
            pend_ap          <= 1'b0;
            cmd_valid_out    <= 1'b0;
            cmd_code_out     <= `LCD_C_NONE;
            cmd_op1_out      <= 6'h00;
            cmd_op2_out      <= 6'h00;
            bank_out         <= 3'h0;
            all_bank_out     <= 1'b0;
            auto_pre_out     <= 1'b0;
            burst32_out      <= 1'b0;
            col9_out         <= 1'b0;
            col_out          <= 10'h000;
            row_out          <= 19'h00000;
            auto_pre_req_out <= 1'b0;
            seq_err_out      <= 1'b0;
        end else begin
            cmd_valid_out    <= 1'b0;
            auto_pre_req_out <= 1'b0;
            if (ck_en_in && cke_in) begin
                case (state)
                    S_IDLE: begin
                        // cs low on a single edge is deselect
                        if (cs_in) begin
                            first_ca <= ca_in;
                            pend     <= code1;
                            state    <= S_SECOND;
                            // sticky flag for a broken pairing
                            if (need_next != `LCD_C_NONE &&
                                need_next != code1)
                                seq_err_out <= 1'b1;
                        end else if (need_next != `LCD_C_NONE) begin
                            seq_err_out <= 1'b1;
                            need_next   <= `LCD_C_NONE;
                        end
                    end
                    S_SECOND: begin
                        state         <= S_IDLE;
                        need_next     <= next_need;
                        cmd_valid_out <= 1'b1;
                        cmd_code_out  <= pend;
                        cmd_op1_out   <= first_ca;
                        cmd_op2_out   <= ca_in;
                        // cs must be low on the second edge
                        if (cs_in || pend == `LCD_C_RFU)
                            seq_err_out <= 1'b1;
                        case (pend)
                            `LCD_C_PRE, `LCD_C_REF: begin
                                all_bank_out <= first_ca[5];
                                bank_out     <= ca_in[2:0];
                            end
                            `LCD_C_WR1, `LCD_C_MWR1, `LCD_C_RD1: begin
                                bank_out     <= ca_in[2:0];
                                col9_out     <= ca_in[4];
                                auto_pre_out <= ca_in[5];
                                pend_bank    <= ca_in[2:0];
                                pend_ap      <= ca_in[5];
                                // mask write is fixed at 16 beats
                                burst32_out  <= bl_otf_en_in &&
                                    pend != `LCD_C_MWR1 && first_ca[5];
                            end
                            `LCD_C_CAS2: begin
                                // c1..c0 are implied zero
                                col_out <= {col9_out, first_ca[5],
                                            ca_in, 2'b00};
                                // access done: close the bank if auto-precharge was set
                                auto_pre_req_out <= pend_ap;
                                bank_out         <= pend_bank;
                                pend_ap          <= 1'b0;
                            end
                            `LCD_C_ACT1: begin
                                bank_out        <= ca_in[2:0];
                                row_out[15:10]  <= {first_ca[5:2],
                                                    ca_in[5:4]};
                            end
                            `LCD_C_ACT2: begin
                                row_out[18:17] <= {first_ca[1],
                                                   first_ca[0]};
                                row_out[9:6]   <= first_ca[5:2];
                                row_out[5:0]   <= ca_in;
                            end
                            default: begin
                                all_bank_out <= all_bank_out;
                            end
                        endcase
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end
    // ------------------------------------------------------------
    // readiness after cke rise and stop guard after commands
    // ------------------------------------------------------------
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in)
            cke_q <= 1'b0;
        else
            cke_q <= cke_in;
    end
    // limitation: the counter is 8 bits, so the sum must stay below 256
    assign rdy_sum = {1'b0, TXP_NCK[7:0]} + {1'b0, `LCD_RDY_EXTRA};
    // the exit interval restarts on cke rise, counted in bus clocks
    lcd_counter #(.W(8)) u_ready (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .load_in    (cke_in && !cke_q),
        .value_in   (rdy_sum[7:0]),
        .tick_in    (ck_en_in),
        .zero_out   (rdy_zero)
    );
    // every issued command reloads the four-clock stop guard
    assign gap_load = cmd_valid_out;
    lcd_counter #(.W(8)) u_gap (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .load_in    (gap_load),
        .value_in   (`LCD_STOP_EXTRA),
        .tick_in    (ck_en_in),
        .zero_out   (gap_zero)
    );
    // limitation: burst and latency timers are the controller's duty
    assign ready_out   = cke_q && rdy_zero;
    // the guard reloads one cycle after the decode, so the decode cycle
    // itself must also hold the flag low
    assign stop_ok_out = gap_zero && !cmd_valid_out &&
                         state == S_IDLE &&
                         need_next == `LCD_C_NONE;
endmodule // lcd_cmd_decode

// *** hw/lcd_consts.vh ***
// constants for the command bus decoder and clock stop monitor
`ifndef LCD_CONSTS_VH
`define LCD_CONSTS_VH
// first-edge opcodes on ca[4:0] (ca0 is bit 0)
`define LCD_OP_MPC      5'h00
`define LCD_OP_PRE      5'h10
`define LCD_OP_REF      5'h08
`define LCD_OP_SRE      5'h18
`define LCD_OP_WR1      5'h04
`define LCD_OP_SRX      5'h14
`define LCD_OP_MWR1     5'h0C
`define LCD_OP_RD1      5'h02
`define LCD_OP_CAS2     5'h12
`define LCD_OP_MRW1     5'h06
`define LCD_OP_MRW2     5'h16
`define LCD_OP_MRR1     5'h0E
// decoded command codes on cmd_code_out
`define LCD_C_NONE      4'h0
`define LCD_C_MPC       4'h1
`define LCD_C_PRE       4'h2
`define LCD_C_REF       4'h3
`define LCD_C_SRE       4'h4
`define LCD_C_SRX       4'h5
`define LCD_C_WR1       4'h6
`define LCD_C_MWR1      4'h7
`define LCD_C_RD1       4'h8
`define LCD_C_CAS2      4'h9
`define LCD_C_MRW1      4'hA
`define LCD_C_MRW2      4'hB
`define LCD_C_MRR1      4'hC
`define LCD_C_ACT1      4'hD
`define LCD_C_ACT2      4'hE
`define LCD_C_RFU       4'hF
// extra clocks after refresh, self refresh or access before clock stop
`define LCD_STOP_EXTRA  8'h04
// default power-down exit latency count, in bus clocks
`define LCD_TXP_NCK     8'h05
`define LCD_RDY_EXTRA   8'h02
`endif

// *** hw/lcd_counter.v ***
// down counter used for readiness and stop-guard intervals
`timescale 1ns/10ps
module lcd_counter #(
    parameter W = 8
) (
    // clock and reset
    input  wire         clk_sys_in,
    input  wire         rst_b_in,
    // control
    input  wire         load_in,
    input  wire [W-1:0] value_in,
    input  wire         tick_in,
    // status
    output wire         zero_out
);
    reg [W-1:0] count;
    // load wins over tick so a fresh interval is never shortened
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count <= {W{1'b0}};
        end else if (load_in) begin
            count <= value_in;
        end else if (tick_in && count != {W{1'b0}}) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign zero_out = (count == {W{1'b0}});
endmodule // lcd_counter

// *** test/lcd_cmd_decode_sva.sv ***
// assertion checker for the command bus decoder, bound to its ports
`timescale 1ns/10ps
`include "lcd_consts.vh"
module lcd_chk #(
    parameter TXP_NCK = 8'h05
) (
    // clock, reset and bus inputs
    input wire       clk_sys_in,
    input wire       rst_b_in,
    input wire       ck_en_in,
    input wire       cke_in,
    input wire       cs_in,
    input wire       bl_otf_en_in,
    // decoder outputs
    input wire       cmd_valid_out,
    input wire [3:0] cmd_code_out,
    input wire       burst32_out,
    input wire       auto_pre_req_out,
    input wire       seq_err_out,
    input wire       ready_out,
    input wire       stop_ok_out
);
    reg [2:0] gap_cnt; // bus edges since last decode, saturates at 4
    default clocking dc @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);
    // count idle edges ourselves so the stop flag is tied to real gaps
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in)
            gap_cnt <= 3'h4;
        else if (cmd_valid_out)
            gap_cnt <= 3'h0;
        else if (ck_en_in && gap_cnt != 3'h4)
            gap_cnt <= gap_cnt + 3'h1;
    end
    valid_one_cycle_a: assert property (
        cmd_valid_out |=> !cmd_valid_out) else $error("valid too long");
    valid_after_half_a: assert property (
        cmd_valid_out |-> $past(ck_en_in && cke_in && !cs_in) ||
        $rose(seq_err_out)) else $error("valid without second half edge");
    ready_needs_cke_a: assert property (
        ready_out |-> cke_in) else $error("ready with cke low");
    ready_exit_wait_a: assert property (
        $rose(cke_in) |-> !ready_out [*3]) else $error("ready too early");
    stop_idle_gap_a: assert property (
        stop_ok_out |-> gap_cnt == 3'h4) else $error("stop ok too early");
    stop_after_cmd_a: assert property (
        cmd_valid_out |-> !stop_ok_out ##1 !stop_ok_out)
        else $error("stop ok right after a command");
    ap_req_on_cas_a: assert property (
        auto_pre_req_out |-> cmd_valid_out && cmd_code_out == `LCD_C_CAS2)
        else $error("auto precharge request outside cas-2");
    burst_forced_a: assert property (
        cmd_valid_out && (cmd_code_out == `LCD_C_MWR1 || !bl_otf_en_in &&
        (cmd_code_out == `LCD_C_WR1 || cmd_code_out == `LCD_C_RD1))
        |-> !burst32_out) else $error("burst32 not forced low");
    err_sticky_a: assert property (
        seq_err_out |=> seq_err_out) else $error("sequence error dropped");
endmodule // lcd_chk
bind lcd_cmd_decode lcd_chk #(.TXP_NCK(TXP_NCK)) lcd_chk_inst (.clk_sys_in,
    .rst_b_in, .ck_en_in, .cke_in, .cs_in, .bl_otf_en_in, .cmd_valid_out,
    .cmd_code_out, .burst32_out, .auto_pre_req_out, .seq_err_out,
    .ready_out, .stop_ok_out);

// *** test/lcd_ctl_model.sv ***
// memory controller model driving the command bus
`timescale 1ns/10ps
module lcd_ctl_model (
    // clock
    input  wire       clk_sys_in,
    // command bus
    output reg        ck_en_out = 1'b0,
    output reg        cke_out = 1'b0,
    output reg        cs_out = 1'b0,
    output reg  [5:0] ca_out = 6'h2A
);
    // bus clock never stops or retimes here, so the stop and change
    // preconditions hold
    // and no rate change or stop needs waits or retuning
    // one bus edge; ca is inverted after it so stale values never help
    task half(input c, input [5:0] a);
        begin
            @(negedge clk_sys_in);
            ck_en_out = 1'b1;
            cs_out = c;
            ca_out = a;
            @(negedge clk_sys_in);
            ck_en_out = 1'b0;
            cs_out = 1'b0; // idle bus is deselect
            ca_out = ~a;
        end
    endtask
    // two-edge command, pairs issued back to back
    task cmd(input [5:0] a, input [5:0] b);
        begin
            half(1'b1, a);
            half(1'b0, b);
        end
    endtask
    // deselect edges with ca changing every time
    task idle(input integer n);
        integer i;
        for (i = 0; i < n; i = i + 1)
            half(1'b0, 6'($urandom));
    endtask
endmodule // lcd_ctl_model

// *** test/test_lcd_cmd_decode.sv ***
// self-checking bench for the command bus decoder
`timescale 1ns/10ps
`include "lcd_consts.vh"
module test_lcd_cmd_decode;
    localparam TXP = 8'h01; // short exit latency keeps the run brief
    reg         clk_sys_in = 1'b0;
    reg         rst_b_in = 1'b0;
    reg         bl_otf_en_in = 1'b0;
    reg         watch = 1'b1;
    wire        ck_en_in, cke_in, cs_in, cmd_valid_out, all_bank_out;
    wire        auto_pre_out, burst32_out, col9_out, auto_pre_req_out;
    wire        seq_err_out, ready_out, stop_ok_out;
    wire  [5:0] ca_in, cmd_op1_out, cmd_op2_out;
    wire  [3:0] cmd_code_out;
    wire  [2:0] bank_out;
    wire  [9:0] col_out;
    wire [18:0] row_out;
    integer     bad_count = 0, check_count = 0, cyc = 0, i, k;
    reg  [28:0] note_q[$], nt; // {first ca, code, field key}
    reg  [18:0] seen, r;
    reg   [9:0] c;
    reg   [5:0] x;
    reg   [4:0] op;
    reg   [2:0] bk;
    reg         ab, ap, bl, blk;
    lcd_cmd_decode #(.TXP_NCK(TXP)) lcd_cmd_decode_inst (.clk_sys_in,
        .rst_b_in, .ck_en_in, .cke_in, .cs_in, .ca_in, .bl_otf_en_in,
        .cmd_valid_out, .cmd_code_out, .cmd_op1_out, .cmd_op2_out,
        .bank_out, .all_bank_out, .auto_pre_out, .burst32_out, .col9_out,
        .col_out, .row_out, .auto_pre_req_out, .seq_err_out, .ready_out,
        .stop_ok_out);
    lcd_ctl_model ctl (.clk_sys_in, .ck_en_out(ck_en_in), .cke_out(cke_in),
        .cs_out(cs_in), .ca_out(ca_in));
    always #4 clk_sys_in = ~clk_sys_in;
    // hang guard: the whole run needs about 740 cycles
    always @(posedge clk_sys_in) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            bad_count = bad_count + 1;
            final_report;
        end
    end
    task final_report;
        begin
            if (bad_count == 0 && check_count > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input string n, input [18:0] e, input [18:0] s);
        begin
            check_count = check_count + 1;
            if (e !== s) begin
                bad_count = bad_count + 1;
                $display("mismatch %s expected %h seen %h", n, e, s);
            end
        end
    endtask
    task go(input [3:0] cd, input [5:0] a, input [5:0] b, input [18:0] y);
        begin
            note_q.push_back({a, cd, y});
            ctl.cmd(a, b);
        end
    endtask
    // c9 at cas-2 is the one carried by the preceding access
    task cas(input a);
        go(`LCD_C_CAS2, {c[8], `LCD_OP_CAS2}, c[7:2], {a, c[9], c[8:2], 2'b0});
    endtask
    // monitor: each decoded command takes the oldest note
    always @(negedge clk_sys_in) begin
        if (cmd_valid_out === 1'b1 && watch) begin
            nt = note_q.size() ? note_q.pop_front() : 29'h1FFFFFFF;
            case (cmd_code_out)
                `LCD_C_PRE, `LCD_C_REF:
                    seen = {all_bank_out, all_bank_out ? 3'h0 : bank_out};
                `LCD_C_WR1, `LCD_C_MWR1, `LCD_C_RD1:
                    seen = {burst32_out, auto_pre_out, col9_out, bank_out};
                `LCD_C_CAS2: seen = {auto_pre_req_out, col_out};
                `LCD_C_ACT1: seen = bank_out;
                `LCD_C_ACT2: seen = row_out & 19'h6FFFF;
                default: seen = cmd_op2_out;
            endcase
            chk("cmd_code", nt[22:19], cmd_code_out);
            chk("cmd_op1", nt[28:23], cmd_op1_out);
            chk("fields", nt[18:0], seen);
        end
    end
    initial begin
        void'($urandom(32'h8e146e70));
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        ctl.cmd({1'b0, `LCD_OP_PRE}, 6'h05); // cke low: must be ignored
        chk("ready_low", 19'h0, ready_out);
        ctl.cke_out = 1'b1;
        ctl.idle(TXP + 1);
        chk("ready_early", 19'h0, ready_out);
        ctl.idle(1);
        chk("ready_late", 19'h1, ready_out);
        for (i = 0; i < 8; i = i + 1) begin
            bl_otf_en_in = i[0];
            {bk, ab, ap, bl, x} = 12'($urandom);
            c = 10'($urandom) & 10'h3F3;
            r = 19'($urandom) | 19'h60000; // act-2 needs ca0 and ca1 high
            go(`LCD_C_PRE, {ab, `LCD_OP_PRE}, {x[2:0], bk}, {ab, ab ? 3'h0 : bk});
            go(`LCD_C_REF, {ab, `LCD_OP_REF}, {x[5:3], bk}, {ab, ab ? 3'h0 : bk});
            ctl.idle(3);
            chk("stop_early", 19'h0, stop_ok_out);
            ctl.idle(1);
            chk("stop_late", 19'h1, stop_ok_out);
            go(`LCD_C_SRE, {x[0], `LCD_OP_SRE}, x, x);
            go(`LCD_C_SRX, {x[1], `LCD_OP_SRX}, {~x}, {~x});
            go(`LCD_C_MPC, {1'b1, `LCD_OP_MPC}, x, x);
            go(`LCD_C_MRW1, {x[2], `LCD_OP_MRW1}, x, x);
            go(`LCD_C_MRW2, {x[3], `LCD_OP_MRW2}, {~x}, {~x});
            for (k = 0; k < 3; k = k + 1) begin
                op = k == 0 ? `LCD_OP_WR1 : k == 1 ? `LCD_OP_MWR1 : `LCD_OP_RD1;
                blk = bl && k != 1;
                go(`LCD_C_WR1 + k[3:0], {blk, op}, {ap, c[9], x[0], bk},
                   {blk && bl_otf_en_in, ap, c[9], bk});
                cas(ap);
            end
            go(`LCD_C_MRR1, {x[4], `LCD_OP_MRR1}, x, x);
            cas(1'b0);
            go(`LCD_C_MPC, {1'b0, `LCD_OP_MPC}, x, x);
            cas(1'b0);
            go(`LCD_C_ACT1, {r[15:12], 2'b01}, {r[11:10], x[0], bk}, bk);
            go(`LCD_C_ACT2, {r[9:6], r[18:17]}, r[5:0],
               {r[18:17], 1'b0, r[15:0]});
        end
        ctl.idle(2);
        chk("notes_left", 19'h0, note_q.size());
        watch = 1'b0;
        // broken pairing, reserved opcode, cs high on a second edge
        for (k = 0; k < 4; k = k + 1) begin
            ctl.half(1'b1, k == 0 ? 6'h04 : k == 1 ? 6'h01 : k == 2 ? 6'h1C
                     : 6'h10);
            ctl.half(k == 3, x);
            ctl.half(k == 0, {1'b0, `LCD_OP_PRE});
            ctl.idle(2);
            chk("seq_err", 19'h1, seq_err_out);
            rst_b_in = 1'b0;
            @(negedge clk_sys_in);
            chk("seq_clear", 19'h0, seq_err_out);
            rst_b_in = 1'b1;
        end
        final_report;
    end
endmodule // test_lcd_cmd_decode
